// >>> core/output_sync_pkg.sv
// Constants and types shared by the output synchronisation parameter block.
package output_sync_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] IDX_MODE_SELECT = 8'h01;
  localparam logic [7:0] IDX_CYCLE_PERIOD = 8'h02;
  localparam logic [7:0] IDX_PULSE_SHIFT = 8'h03;
  localparam logic [7:0] IDX_SUPPORTED = 8'h04;
  localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
  localparam logic [7:0] IDX_MIN_GAP = 8'h06;
  localparam logic [7:0] IDX_MEASURE_CMD = 8'h08;
  localparam logic [7:0] IDX_SECOND_DELAY = 8'h09;
  localparam logic [7:0] IDX_MISSED_COUNT = 8'h0b;
  localparam logic [7:0] IDX_OVERRUN_COUNT = 8'h0c;
  localparam logic [7:0] IDX_GAP_SHORT_COUNT = 8'h0d;
  localparam logic [7:0] IDX_LATE_FLAG = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;

  // Reset values.
  localparam logic [7:0] RST_ENTRY_COUNT = 8'h20;
  localparam logic [15:0] RST_MODE_SELECT = 16'h0001;
  localparam logic [31:0] RST_CYCLE_PERIOD = 32'h0007_a120;
  localparam logic [31:0] RST_PULSE_SHIFT = 32'h0000_0000;
  localparam logic [15:0] RST_SUPPORTED = 16'hc007;
  localparam logic [31:0] RST_MIN_CYCLE = 32'h0000_4e20;
  localparam logic [31:0] RST_MIN_GAP = 32'h0000_0000;
  localparam logic [15:0] RST_MEASURE_CMD = 16'h0000;
  localparam logic [31:0] RST_SECOND_DELAY = 32'h0000_0000;
  localparam logic [15:0] RST_ERR_COUNT = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // Field positions.
  localparam int CMD_MEASURE_BIT = 0;
  localparam int IRQ_MISSED_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_GAP_SHORT_BIT = 2;
  localparam int IRQ_LATE_BIT = 3;

  // Timing: one clock period in nanoseconds, the step of every time counter.
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [31:0] NS_PER_CYCLE = 32'(CLK_PERIOD_NS);

  // Synchronisation modes.
  typedef enum logic [1:0] {
    MODE_FREE_RUN = 2'd0,
    MODE_BUFFER_EVENT = 2'd1,
    MODE_FIRST_PULSE = 2'd2,
    MODE_SECOND_PULSE = 2'd3
  } sync_mode_e;

  // Measurement sequencer states, Gray coded along idle, clear, run.
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_CLEAR = 2'b01,
    MEAS_RUN = 2'b11
  } meas_state_e;

  // Link events after synchronisation, one-cycle pulses plus the state level.
  typedef struct packed {
    logic buffer_event;
    logic first_sync_pulse;
    logic second_sync_pulse;
    logic outputs_driven;
    logic operational;
  } link_events_s;

  // Measured maxima.
  typedef struct packed {
    logic [31:0] shift;
    logic [31:0] min_cycle;
    logic [31:0] min_gap;
    logic [31:0] delay;
  } meas_times_s;

endpackage

// >>> core/output_sync_parameters.sv
// Output synchronisation parameters, measurement and error counters behind APB.
`timescale 1ns/1ns
module output_sync_parameters (
  // Clock, reset and clock enable.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link events from the fieldbus side, asynchronous.
  input wire logic buffer_event_i,
  input wire logic first_sync_pulse_i,
  input wire logic second_sync_pulse_i,
  input wire logic outputs_driven_i,
  input wire logic operational_i,
  // Cycle start towards the output stage, and interrupt.
  output logic cycle_start_o,
  output logic irq_o
);
  import output_sync_pkg::*;

  localparam int NUM_PINS = 5;

  logic rst_second_sync_pulse;
  logic rst_n;
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_prev;
  link_events_s ev;

  logic [15:0] mode_select;
  logic [31:0] cycle_period;
  logic [15:0] measure_cmd;
  meas_state_e meas_state;
  meas_times_s meas;
  logic [15:0] missed_count;
  logic [15:0] overrun_count;
  logic [15:0] gap_short_count;
  logic late_flag;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  logic [31:0] since_first;
  logic [31:0] since_second;
  logic [31:0] since_start;
  logic [31:0] free_timer;
  logic buffer_seen;
  logic cycle_pending;
  sync_mode_e mode;
  logic dc_mode;
  logic cycle_start;
  logic miss_ev;
  logic overrun_ev;
  logic gap_short_ev;
  logic late_ev;
  logic [3:0] irq_set;

  logic setup;
  logic wr_en;
  logic [7:0] reg_idx;
  logic [31:0] read_data;
  logic read_err;

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_second_sync_pulse <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_second_sync_pulse <= 1'b1;
      rst_n <= rst_second_sync_pulse;
    end
  end

  assign pin_raw = {buffer_event_i, first_sync_pulse_i, second_sync_pulse_i,
                    outputs_driven_i, operational_i};

  // Three-stage pin synchroniser; a level counts only once stages two and
  // three agree, which also rejects a single-cycle glitch.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        pin_level[i] <= 1'b0;
        pin_prev[i] <= 1'b0;
      end else if (ce_i) begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          pin_level[i] <= s3;
        end
        pin_prev[i] <= pin_level[i];
      end
    end
  end

  // Rising edges become one-cycle event pulses; operational stays a level.
  assign ev.buffer_event = pin_level[4] & ~pin_prev[4];
  assign ev.first_sync_pulse = pin_level[3] & ~pin_prev[3];
  assign ev.second_sync_pulse = pin_level[2] & ~pin_prev[2];
  assign ev.outputs_driven = pin_level[1] & ~pin_prev[1];
  assign ev.operational = pin_level[0];

  // Values above three are stored but treated as free run.
  assign mode = (mode_select[15:2] == 14'h0000) ? sync_mode_e'(mode_select[1:0])
                                                : MODE_FREE_RUN;
  assign dc_mode = (mode == MODE_FIRST_PULSE) || (mode == MODE_SECOND_PULSE);

  // The event that starts a cycle depends on the mode.
  always_comb begin
    case (mode)
      MODE_FREE_RUN: cycle_start = (free_timer + NS_PER_CYCLE >= cycle_period);
      MODE_BUFFER_EVENT: cycle_start = ev.buffer_event;
      MODE_FIRST_PULSE: cycle_start = ev.first_sync_pulse;
      MODE_SECOND_PULSE: cycle_start = ev.second_sync_pulse;
      default: cycle_start = 1'b0;
    endcase
  end

  // Error events.
  assign miss_ev = dc_mode & ev.operational & ev.first_sync_pulse & ~buffer_seen;
  assign overrun_ev = ev.operational & cycle_start & cycle_pending;
  assign gap_short_ev = dc_mode & ev.second_sync_pulse & (since_first < meas.min_gap);
  assign late_ev = dc_mode & ev.first_sync_pulse & cycle_pending;
  assign irq_set = {late_ev, gap_short_ev, overrun_ev, miss_ev};

  // Free-run local timer, counting the cycle period in nanoseconds.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      free_timer <= 32'h0000_0000;
    end else if (ce_i) begin
      if (mode != MODE_FREE_RUN || cycle_start) begin
        free_timer <= 32'h0000_0000;
      end else begin
        free_timer <= free_timer + NS_PER_CYCLE;
      end
    end
  end

  // Elapsed-time counters; steps of 40 from 40 never meet the all-ones stop, so they wrap. An event loads
  // one period, so the value read at a later edge covers every cycle in between.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      since_first <= 32'h0000_0000;
      since_second <= 32'h0000_0000;
      since_start <= 32'h0000_0000;
    end else if (ce_i) begin
      if (ev.first_sync_pulse) begin
        since_first <= NS_PER_CYCLE;
      end else if (since_first != 32'hffff_ffff) begin
        since_first <= since_first + NS_PER_CYCLE;
      end
      if (ev.second_sync_pulse) begin
        since_second <= NS_PER_CYCLE;
      end else if (since_second != 32'hffff_ffff) begin
        since_second <= since_second + NS_PER_CYCLE;
      end
      if (cycle_start) begin
        since_start <= NS_PER_CYCLE;
      end else if (since_start != 32'hffff_ffff) begin
        since_start <= since_start + NS_PER_CYCLE;
      end
    end
  end

  // Cycle bookkeeping: pending from cycle start to output drive, and whether
  // a buffer event arrived since the last first sync pulse.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cycle_pending <= 1'b0;
      buffer_seen <= 1'b0;
      cycle_start_o <= 1'b0;
    end else if (ce_i) begin
      cycle_start_o <= cycle_start;
      if (cycle_start) begin
        cycle_pending <= 1'b1;
      end else if (ev.outputs_driven) begin
        cycle_pending <= 1'b0;
      end
      if (ev.buffer_event) begin
        buffer_seen <= 1'b1;
      end else if (ev.first_sync_pulse) begin
        buffer_seen <= 1'b0;
      end
    end
  end

  // APB decode; the slave answers in the first access cycle.
  assign setup = psel_i & ~penable_i & ~pready_o;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign reg_idx = paddr_i[9:2];

  // Configuration registers written by software.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_select <= RST_MODE_SELECT;
      cycle_period <= RST_CYCLE_PERIOD;
      measure_cmd <= RST_MEASURE_CMD;
      irq_mask <= RST_IRQ;
    end else if (ce_i && wr_en) begin
      case (reg_idx)
        IDX_MODE_SELECT: mode_select <= pwdata_i[15:0];
        IDX_CYCLE_PERIOD: cycle_period <= pwdata_i;
        IDX_MEASURE_CMD: measure_cmd <= pwdata_i[15:0];
        IDX_IRQ_MASK: irq_mask <= pwdata_i[3:0];
        default: ;
      endcase
    end
  end

  // Measurement sequencer: a start passes through a clear cycle first.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meas_state <= MEAS_IDLE;
    end else if (ce_i) begin
      case (meas_state)
        MEAS_IDLE: begin
          if (measure_cmd[CMD_MEASURE_BIT]) begin
            meas_state <= MEAS_CLEAR;
          end
        end
        MEAS_CLEAR: begin
          meas_state <= measure_cmd[CMD_MEASURE_BIT] ? MEAS_RUN : MEAS_IDLE;
        end
        MEAS_RUN: begin
          if (!measure_cmd[CMD_MEASURE_BIT]) begin
            meas_state <= MEAS_IDLE;
          end
        end
        default: meas_state <= MEAS_IDLE;
      endcase
    end
  end

  // Measured maxima; the minimum-cycle entry keeps its default until the
  // first measurement clears it, so software always sees a sane figure.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meas.shift <= RST_PULSE_SHIFT;
      meas.min_cycle <= RST_MIN_CYCLE;
      meas.min_gap <= RST_MIN_GAP;
      meas.delay <= RST_SECOND_DELAY;
    end else if (ce_i) begin
      if (meas_state == MEAS_CLEAR) begin
        meas <= '0;
      end else if (meas_state == MEAS_RUN) begin
        if (ev.outputs_driven && dc_mode && since_first > meas.shift) begin
          meas.shift <= since_first;
        end
        if (ev.outputs_driven && since_start > meas.min_cycle) begin
          meas.min_cycle <= since_start;
        end
        if (ev.second_sync_pulse && dc_mode && since_first > meas.min_gap) begin
          meas.min_gap <= since_first;
        end
        if (ev.outputs_driven && dc_mode && since_second > meas.delay) begin
          meas.delay <= since_second;
        end
      end
    end
  end

  // Saturating error counters.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      missed_count <= RST_ERR_COUNT;
      overrun_count <= RST_ERR_COUNT;
      gap_short_count <= RST_ERR_COUNT;
    end else if (ce_i) begin
      if (miss_ev && missed_count != 16'hffff) begin
        missed_count <= missed_count + 16'h0001;
      end
      if (overrun_ev && overrun_count != 16'hffff) begin
        overrun_count <= overrun_count + 16'h0001;
      end
      if (gap_short_ev && gap_short_count != 16'hffff) begin
        gap_short_count <= gap_short_count + 16'h0001;
      end
    end
  end

  // Late flag: a drive clears it in the first and second pulse modes, in other modes only a drive with no cycle pending.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      late_flag <= 1'b0;
    end else if (ce_i) begin
      if (late_ev) begin
        late_flag <= 1'b1;
      end else if (ev.outputs_driven && !cycle_pending) begin
        late_flag <= 1'b0;
      end else if (ev.outputs_driven && dc_mode) begin
        late_flag <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins over the
  // clear so nothing arriving in the clearing cycle is lost.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && reg_idx == IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata_i[3:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Read multiplexer; narrow registers sit in the low bits.
  always_comb begin
    read_data = 32'h0000_0000;
    read_err = 1'b0;
    case (reg_idx)
      IDX_ENTRY_COUNT: read_data = {24'h00_0000, RST_ENTRY_COUNT};
      IDX_MODE_SELECT: read_data = {16'h0000, mode_select};
      IDX_CYCLE_PERIOD: read_data = cycle_period;
      IDX_PULSE_SHIFT: read_data = meas.shift;
      IDX_SUPPORTED: read_data = {16'h0000, RST_SUPPORTED};
      IDX_MIN_CYCLE: read_data = meas.min_cycle;
      IDX_MIN_GAP: read_data = meas.min_gap;
      IDX_MEASURE_CMD: read_data = {16'h0000, measure_cmd};
      IDX_SECOND_DELAY: read_data = meas.delay;
      IDX_MISSED_COUNT: read_data = {16'h0000, missed_count};
      IDX_OVERRUN_COUNT: read_data = {16'h0000, overrun_count};
      IDX_GAP_SHORT_COUNT: read_data = {16'h0000, gap_short_count};
      IDX_LATE_FLAG: read_data = {31'h0000_0000, late_flag};
      IDX_IRQ_STATUS: read_data = {28'h000_0000, irq_status};
      IDX_IRQ_MASK: read_data = {28'h000_0000, irq_mask};
      default: read_err = 1'b1;
    endcase
  end

  // APB answer: ready, data and error registered at the end of setup.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (setup) begin
        pready_o <= 1'b1;
        pslverr_o <= read_err | (paddr_i[1:0] != 2'b00);
        prdata_o <= pwrite_i ? 32'h0000_0000 : read_data;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

endmodule

// >>> dv/output_sync_parameters_assertions.sv
// Port-level assertions for the output synchronisation parameter block.
`timescale 1ns/1ns
module output_sync_parameters_assertions (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // APB.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Cycle start.
  input wire logic cycle_start_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // A setup cycle that the block takes, and a read setup at one address.
  sequence any_setup;
    psel_i && !penable_i && ce_i;
  endsequence
  sequence read_at(logic [9:0] a);
    psel_i && !penable_i && ce_i && !pwrite_i && paddr_i == a;
  endsequence

  chk_ready_follows: assert property (any_setup |=> pready_o)
    else $error("ready missing after setup");
  chk_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_ready_cause: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready without a setup cycle");
  chk_error_qualified: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_misalign_error: assert property (any_setup and paddr_i[1:0] != 2'b00 |=> pslverr_o)
    else $error("misaligned access accepted");
  chk_unmapped_read: assert property (read_at(10'h01c) |=> pslverr_o && prdata_o == 0)
    else $error("unmapped read not refused");
  chk_entry_count: assert property (read_at(10'h000) |=> prdata_o == 32'h0000_0020)
    else $error("entry count wrong");
  chk_modes_bitmap: assert property (read_at(10'h010) |=> prdata_o == 32'h0000_c007)
    else $error("supported modes wrong");
  chk_start_pulse: assert property ($rose(cycle_start_o) |=> !cycle_start_o)
    else $error("cycle start longer than one cycle");
endmodule

// >>> dv/fieldbus_master_model.sv
// Behavioural model of the fieldbus master driving the event and state pins.
`timescale 1ns/1ns
module fieldbus_master_model (
  // Bench clock.
  input wire logic clk_i,
  // Pins towards the block.
  output logic buffer_event_o,
  output logic first_sync_pulse_o,
  output logic second_sync_pulse_o,
  output logic outputs_driven_o,
  output logic operational_o
);
  logic [3:0] pins;

  // Index 0 buffer event, 1 first pulse, 2 second pulse, 3 outputs driven.
  assign {outputs_driven_o, second_sync_pulse_o, first_sync_pulse_o, buffer_event_o} = pins;

  initial begin
    pins = 4'h0;
    operational_o = 1'b0;
  end

  // Three cycles high and three low, wider than the block's input filter needs.
  task automatic pulse(input int sel);
    @(posedge clk_i);
    pins[sel] <= 1'b1;
    repeat (3) @(posedge clk_i);
    pins[sel] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // Operational state is a level.
  task automatic set_op(input logic v);
    @(posedge clk_i);
    operational_o <= v;
  endtask
endmodule

// >>> dv/tb_output_sync_parameters.sv
// Self-checking bench for the output synchronisation parameter block.
`timescale 1ns/1ns
module tb_output_sync_parameters;
  import output_sync_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [9:0] paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, cycle_start_o, irq_o;
  wire buf_evt, pulse_a, pulse_b, driven, oper;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_0003;
  logic [31:0] rd;
  logic err;
  localparam logic [7:0] RIDX [15] = '{IDX_ENTRY_COUNT, IDX_MODE_SELECT, IDX_CYCLE_PERIOD,
    IDX_PULSE_SHIFT, IDX_SUPPORTED, IDX_MIN_CYCLE, IDX_MIN_GAP, IDX_MEASURE_CMD,
    IDX_SECOND_DELAY, IDX_MISSED_COUNT, IDX_OVERRUN_COUNT, IDX_GAP_SHORT_COUNT,
    IDX_LATE_FLAG, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  localparam logic [31:0] RVAL [15] = '{32'(RST_ENTRY_COUNT), 32'(RST_MODE_SELECT),
    RST_CYCLE_PERIOD, RST_PULSE_SHIFT, 32'(RST_SUPPORTED), RST_MIN_CYCLE, RST_MIN_GAP,
    32'(RST_MEASURE_CMD), RST_SECOND_DELAY, 32'(RST_ERR_COUNT), 32'(RST_ERR_COUNT),
    32'(RST_ERR_COUNT), 32'h0000_0000, 32'(RST_IRQ), 32'(RST_IRQ)};

  // Clock of 40 ns period.
  always #20 core_clk_i = ~core_clk_i;

  output_sync_parameters output_sync_parameters_inst (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .buffer_event_i(buf_evt), .first_sync_pulse_i(pulse_a), .second_sync_pulse_i(pulse_b),
    .outputs_driven_i(driven), .operational_i(oper),
    .cycle_start_o(cycle_start_o), .irq_o(irq_o));

  fieldbus_master_model fieldbus_master_model_inst (
    .clk_i(core_clk_i), .buffer_event_o(buf_evt), .first_sync_pulse_o(pulse_a),
    .second_sync_pulse_o(pulse_b), .outputs_driven_o(driven), .operational_o(oper));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // No wait limit here: the bench timeout ends a transfer that never completes.
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Cycles until the next cycle start, bounded so a silent design cannot hang here.
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (cycle_start_o !== 1'b1 && n < 100);
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin : main
    int n;
    logic [31:0] m0, o0;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    // Reset values, and read-only places keep them after a random write.
    foreach (RIDX[i]) begin
      apb(1'b0, ba(RIDX[i]), 32'h0000_0000);
      check(rd, RVAL[i]);
      if (!(RIDX[i] inside {IDX_MODE_SELECT, IDX_CYCLE_PERIOD, IDX_MEASURE_CMD, IDX_IRQ_MASK})) begin
        seed = xorshift(seed);
        apb(1'b1, ba(RIDX[i]), seed);
        apb(1'b0, ba(RIDX[i]), 32'h0000_0000);
        check(rd, RVAL[i]);
      end
    end
    // Random values in the mode select and cycle period registers read back whole.
    repeat (8) begin
      seed = xorshift(seed);
      apb(1'b1, ba(IDX_MODE_SELECT), {16'h0000, seed[15:0]});
      apb(1'b0, ba(IDX_MODE_SELECT), 32'h0000_0000);
      check(rd, {16'h0000, seed[15:0]});
      seed = xorshift(seed);
      apb(1'b1, ba(IDX_CYCLE_PERIOD), seed);
      apb(1'b0, ba(IDX_CYCLE_PERIOD), 32'h0000_0000);
      check(rd, seed);
    end
    // Unmapped and misaligned accesses are refused.
    apb(1'b0, ba(8'h07), 32'h0000_0000);
    check({rd[31:1], err}, 32'h0000_0001);
    apb(1'b0, 10'h005, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    // Each event-driven mode starts a cycle on its own pin.
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, ba(IDX_MODE_SELECT), 32'(m));
      fork
        fieldbus_master_model_inst.pulse(m - 1);
        wait_start(n);
      join
      // The event passes the pin filter first, so the start cannot come at once.
      check(32'(n > 4 && n < 12), 32'h0000_0001);
    end
    // Free run repeats at the 400 ns period held in the cycle register.
    apb(1'b1, ba(IDX_CYCLE_PERIOD), 32'h0000_0190);
    apb(1'b1, ba(IDX_MODE_SELECT), 32'(MODE_FREE_RUN));
    wait_start(n);
    wait_start(n);
    check(32'(n), 32'h0000_0190 / NS_PER_CYCLE);
    // Clock enable low freezes the timer; fifteen idle cycles would otherwise
    // bring the next start after five, so a full period proves the freeze.
    ce_i <= 1'b0;
    repeat (15) @(posedge core_clk_i);
    ce_i <= 1'b1;
    wait_start(n);
    check(32'(n), 32'h0000_0190 / NS_PER_CYCLE);
    // Distributed-clock cycles while operational; counters are compared to baselines.
    apb(1'b1, ba(IDX_MODE_SELECT), 32'(MODE_FIRST_PULSE));
    fieldbus_master_model_inst.set_op(1'b1);
    fieldbus_master_model_inst.pulse(3);
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_MISSED_COUNT), 32'h0000_0000);
    m0 = rd;
    apb(1'b0, ba(IDX_OVERRUN_COUNT), 32'h0000_0000);
    o0 = rd;
    apb(1'b1, ba(IDX_IRQ_STATUS), 32'h0000_000f);
    apb(1'b1, ba(IDX_IRQ_MASK), 32'h0000_0001);
    fieldbus_master_model_inst.pulse(1);
    fieldbus_master_model_inst.pulse(3);
    repeat (4) @(posedge core_clk_i);
    check({31'h0000_0000, irq_o}, 32'h0000_0001);
    apb(1'b0, ba(IDX_MISSED_COUNT), 32'h0000_0000);
    check(rd, m0 + 1);
    apb(1'b1, ba(IDX_IRQ_STATUS), 32'h0000_0001);
    repeat (3) @(posedge core_clk_i);
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    // Measured shift is first pulse to drive, seven cycles apart; restart clears it.
    apb(1'b1, ba(IDX_MEASURE_CMD), 32'h0000_0001);
    fieldbus_master_model_inst.pulse(0);
    fieldbus_master_model_inst.pulse(1);
    fieldbus_master_model_inst.pulse(3);
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_PULSE_SHIFT), 32'h0000_0000);
    check(rd, 32'h0000_0007 * NS_PER_CYCLE);
    apb(1'b1, ba(IDX_MEASURE_CMD), 32'h0000_0000);
    apb(1'b1, ba(IDX_MEASURE_CMD), 32'h0000_0001);
    // The sequencer needs two cycles before the clear lands.
    repeat (2) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_PULSE_SHIFT), 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Two cycles without a drive: one overrun, late outputs, masked interrupt stays low.
    fieldbus_master_model_inst.pulse(0);
    fieldbus_master_model_inst.pulse(1);
    fieldbus_master_model_inst.pulse(0);
    fieldbus_master_model_inst.pulse(1);
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_OVERRUN_COUNT), 32'h0000_0000);
    check(rd, o0 + 1);
    apb(1'b0, ba(IDX_LATE_FLAG), 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b0, ba(IDX_MISSED_COUNT), 32'h0000_0000);
    check(rd, m0 + 1);
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    fieldbus_master_model_inst.pulse(3);
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_LATE_FLAG), 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // A seven-cycle gap sets the largest gap, then a two-cycle gap is too short.
    fieldbus_master_model_inst.pulse(1);
    fieldbus_master_model_inst.pulse(2);
    fork
      fieldbus_master_model_inst.pulse(1);
      begin
        repeat (2) @(posedge core_clk_i);
        fieldbus_master_model_inst.pulse(2);
      end
    join
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, ba(IDX_MIN_GAP), 32'h0000_0000);
    check(rd, 32'h0000_0007 * NS_PER_CYCLE);
    apb(1'b0, ba(IDX_GAP_SHORT_COUNT), 32'h0000_0000);
    check(rd, 32'h0000_0001);
    test_done();
  end
endmodule

bind output_sync_parameters output_sync_parameters_assertions
  output_sync_parameters_assertions_inst (.core_clk_i, .reset_n_i, .ce_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .cycle_start_o);
